/* File: common/bdct_consts.svh */
// Constants for the branch decode and cycle timing block.
// Assumes inclusion by bare name from common/.
`ifndef BDCT_CONSTS_SVH
`define BDCT_CONSTS_SVH
`define BDCT_PFX_LONG   8'h10
`define BDCT_OP_BRA     8'h20
`define BDCT_OP_BRN     8'h21
`define BDCT_OP_BSR     8'h8D
`define BDCT_OP_LBRA    8'h16
`define BDCT_OP_LONG_BRANCH_TO_SUBROUTINE    8'h17
`define BDCT_OP_PUSH_HARDWARE_STACK    8'h34
`define BDCT_OP_PULL_HARDWARE_STACK    8'h35
`define BDCT_OP_PUSH_USER_STACK    8'h36
`define BDCT_OP_PULL_USER_STACK    8'h37
`define BDCT_OP_SWI1    8'h3F
`define BDCT_PFX_SOFT_INTERRUPT_THREE   8'h11
`define BDCT_OP_EXG     8'h1E
`define BDCT_OP_TFR     8'h1F
`define BDCT_BR_HI      4'h2
`define BDCT_SHORT_CYC  5'h03
`define BDCT_SHORT_LEN  3'h2
`define BDCT_LONG_NT    5'h05
`define BDCT_LONG_TK    5'h06
`define BDCT_LONG_LEN   3'h4
`define BDCT_LBRA_CYC   5'h05
`define BDCT_LBRA_LEN   3'h3
`define BDCT_BSR_CYC    5'h07
`define BDCT_LONG_BRANCH_TO_SUBROUTINE_CYC   5'h09
`define BDCT_STK_BASE   5'h05
`define BDCT_STK_LEN    3'h2
`define BDCT_SWI_CYC    5'h13
`define BDCT_SWI23_CYC  5'h14
`define BDCT_XFR_CYC    5'h06
`define BDCT_EXG_CYC    5'h08
`define BDCT_IDX_CYC    5'h04
`define BDCT_IDX_LEN    3'h2
`define BDCT_CC_C       0
`define BDCT_CC_V       1
`define BDCT_CC_Z       2
`define BDCT_CC_N       3
`define BDCT_CC_I       4
`define BDCT_CC_H       5
`define BDCT_CC_F       6
`define BDCT_RSEL_WIDE  3
`define BDCT_HALF_BIT   4
`define BDCT_SIGN_BIT   7
`endif

/* File: common/bdct_pkg.sv */
// Types shared by the branch decode and cycle timing block.
// Assumes bdct_consts.svh is on the include path.
package bdct_pkg;
  typedef enum logic [2:0] {
    BDCT_IDLE = 3'b001,
    BDCT_PFX  = 3'b010,
    BDCT_DONE = 3'b100
  } bdct_state_t;

  typedef struct packed {
    logic        valid;
    logic        taken;
    logic [15:0] target;
    logic [4:0]  cycles;
    logic [2:0]  nbytes;
    logic        push_ret;
    logic        set_if;
    logic        legal;
  } bdct_res_t;

  typedef struct packed {
    bdct_state_t state;
    logic [7:0]  pfx;
    bdct_res_t   res;
  } bdct_st_t;

  typedef struct packed {
    logic [7:0] h;
    logic       half;
    logic       carry;
  } bdct_add_t;
endpackage

/* File: logic/bdct_cond.sv */
// Branch condition evaluator for the relative branch families.
// Assumes a flag byte with C,V,Z,N in bits 0..3.
`timescale 1ns/1ps
`default_nettype none
`include "bdct_consts.svh"
module bdct_cond
  import bdct_pkg::*;
(
  input  wire logic [3:0] i_cond,
  input  wire logic [7:0] i_cc,
  output logic            o_take
);
  logic c;
  logic v;
  logic z;
  logic n;
  logic base;
  always_comb begin
    c = i_cc[`BDCT_CC_C];
    v = i_cc[`BDCT_CC_V];
    z = i_cc[`BDCT_CC_Z];
    n = i_cc[`BDCT_CC_N];
    case (i_cond[3:1])
      3'h0:    base = 1'b1;
      3'h1:    base = ~(c | z);
      3'h2:    base = ~c;
      3'h3:    base = ~z;
      3'h4:    base = ~v;
      3'h5:    base = ~n;
      3'h6:    base = ~(n ^ v);
      default: base = ~((n ^ v) | z);
    endcase
    // Odd codes are the complement of the pair
    o_take = i_cond[0] ? ~base : base;
  end
endmodule
`default_nettype wire

/* File: logic/bdct_decode.sv */
// Branch decode, cycle and byte timing, flag helpers.
// Assumes opcode bytes arrive one per valid cycle from program memory.
//
// Behaviour
// - Short branches are two bytes and three cycles, taken or not.
// - A 10 prefix before a short branch opcode forms a long branch.
// - Long conditional branches are four bytes, six cycles taken, five not.
// - Stack push and pull take five cycles plus one per byte moved.
// - The first soft interrupt sets I and F; the others leave them alone.
// - Exchange and transfer accept only pairs of equal register width.
// - Simple branches test one flag, set or clear.
// - Signed branches use two's-complement flags, in complement pairs.
// - Unsigned branches use carry and zero.
// - Indexed counts are base values plus the postbyte extra counts.
// - Half-carry after the marked instructions is left unspecified.
// - The special carry case sets carry to bit 7 of the result.
// - Half-carry captures the carry out of bit 3 of an 8-bit add.
`timescale 1ns/1ps
`default_nettype none
`include "bdct_consts.svh"
module bdct_decode
  import bdct_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_op_valid,
  input  wire logic [7:0]  i_op,
  input  wire logic [15:0] i_offset,
  input  wire logic [15:0] i_pc,
  input  wire logic [7:0]  i_cc,
  input  wire logic [7:0]  i_postbyte,
  input  wire logic [3:0]  i_idx_cyc,
  input  wire logic [1:0]  i_idx_len,
  input  wire logic        i_idx_mode,
  input  wire logic [7:0]  i_add_a,
  input  wire logic [7:0]  i_add_b,
  output logic             o_valid,
  output logic             o_taken,
  output logic [15:0]      o_target,
  output logic [4:0]       o_cycles,
  output logic [2:0]       o_nbytes,
  output logic             o_push_ret,
  output logic             o_set_if,
  output logic             o_legal,
  output logic             o_half,
  output logic             o_carry,
  output logic             o_carry_b7
);
  bdct_st_t  st;
  bdct_st_t  next_st;
  logic      take;
  bdct_add_t add_r;

  // Count of bytes in a push or pull mask; bits 4 to 7 (PC, U/S, Y, X) are 2 bytes, the rest 1
  function automatic logic [4:0] stack_bytes(input logic [7:0] m);
    logic [4:0] s;
    s = 5'h00;
    for (int k = 0; k < 8; k++) begin
      if (m[k]) begin
        s = s + ((k >= 4) ? 5'h02 : 5'h01);
      end
    end
    stack_bytes = s;
  endfunction

  function automatic logic reg_wide(input logic [3:0] r);
    reg_wide = ~r[`BDCT_RSEL_WIDE];
  endfunction

  function automatic logic [15:0] rel_target(input logic [15:0] pc,
                                             input logic [15:0] off);
    rel_target = pc + off;
  endfunction

  function automatic bdct_add_t add8(input logic [7:0] a,
                                     input logic [7:0] b);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    full = {1'b0, a} + {1'b0, b};
    add8.h = full[7:0];
    add8.half = lo[`BDCT_HALF_BIT];
    add8.carry = full[8];
  endfunction

  bdct_cond u_cond (
    .i_cond (i_op[3:0]),
    .i_cc   (i_cc),
    .o_take (take)
  );

  always_comb begin
    next_st = st;
    next_st.res.valid = 1'b0;
    case (st.state)
      BDCT_IDLE, BDCT_DONE: begin
        next_st.state = BDCT_IDLE;
        if (i_op_valid) begin
          if (i_op == `BDCT_PFX_LONG || i_op == `BDCT_PFX_SOFT_INTERRUPT_THREE) begin
            next_st.state = BDCT_PFX;
            next_st.pfx = i_op;
          end else begin
            next_st.state = BDCT_DONE;
            next_st.pfx = 8'h00;
            next_st.res.valid = 1'b1;
            next_st.res.taken = 1'b0;
            next_st.res.push_ret = 1'b0;
            next_st.res.set_if = 1'b0;
            next_st.res.legal = 1'b1;
            next_st.res.target = i_pc;
            next_st.res.nbytes = 3'h1;
            next_st.res.cycles = 5'h00;
            if (i_op[7:4] == `BDCT_BR_HI) begin
              next_st.res.cycles = `BDCT_SHORT_CYC;
              next_st.res.nbytes = `BDCT_SHORT_LEN;
              next_st.res.taken = take;
              if (take) begin
                next_st.res.target = rel_target(i_pc,
                  {{8{i_offset[7]}}, i_offset[7:0]});
              end
            end else if (i_op == `BDCT_OP_BSR) begin
              next_st.res.cycles = `BDCT_BSR_CYC;
              next_st.res.nbytes = `BDCT_SHORT_LEN;
              next_st.res.taken = 1'b1;
              next_st.res.push_ret = 1'b1;
              next_st.res.target = rel_target(i_pc,
                {{8{i_offset[7]}}, i_offset[7:0]});
            end else if (i_op == `BDCT_OP_LBRA ||
                         i_op == `BDCT_OP_LONG_BRANCH_TO_SUBROUTINE) begin
              next_st.res.cycles = (i_op == `BDCT_OP_LONG_BRANCH_TO_SUBROUTINE) ?
                `BDCT_LONG_BRANCH_TO_SUBROUTINE_CYC : `BDCT_LBRA_CYC;
              next_st.res.nbytes = `BDCT_LBRA_LEN;
              next_st.res.taken = 1'b1;
              next_st.res.push_ret = (i_op == `BDCT_OP_LONG_BRANCH_TO_SUBROUTINE);
              next_st.res.target = rel_target(i_pc, i_offset);
            end else if (i_op == `BDCT_OP_PUSH_HARDWARE_STACK || i_op == `BDCT_OP_PULL_HARDWARE_STACK ||
                         i_op == `BDCT_OP_PUSH_USER_STACK ||
                         i_op == `BDCT_OP_PULL_USER_STACK) begin
              next_st.res.cycles = `BDCT_STK_BASE +
                stack_bytes(i_postbyte);
              next_st.res.nbytes = `BDCT_STK_LEN;
            end else if (i_op == `BDCT_OP_SWI1) begin
              next_st.res.cycles = `BDCT_SWI_CYC;
              next_st.res.set_if = 1'b1;
            end else if (i_op == `BDCT_OP_EXG || i_op == `BDCT_OP_TFR) begin
              next_st.res.cycles = (i_op == `BDCT_OP_EXG) ?
                `BDCT_EXG_CYC : `BDCT_XFR_CYC;
              next_st.res.nbytes = `BDCT_SHORT_LEN;
              next_st.res.legal = reg_wide(i_postbyte[7:4]) ==
                                  reg_wide(i_postbyte[3:0]);
            end else if (i_idx_mode) begin
              next_st.res.cycles = 5'(i_idx_cyc) + `BDCT_IDX_CYC;
              next_st.res.nbytes = 3'(i_idx_len) + `BDCT_IDX_LEN;
            end
          end
        end
      end
      BDCT_PFX: begin
        if (i_op_valid) begin
          next_st.state = BDCT_DONE;
          next_st.res.valid = 1'b1;
          next_st.res.taken = 1'b0;
          next_st.res.push_ret = 1'b0;
          next_st.res.set_if = 1'b0;
          next_st.res.legal = 1'b1;
          next_st.res.target = i_pc;
          next_st.res.nbytes = 3'h2;
          next_st.res.cycles = 5'h00;
          if (i_op == `BDCT_OP_SWI1) begin
            next_st.res.cycles = `BDCT_SWI23_CYC;
          end else if (st.pfx == `BDCT_PFX_LONG &&
                       i_op[7:4] == `BDCT_BR_HI) begin
            next_st.res.nbytes = `BDCT_LONG_LEN;
            next_st.res.taken = take;
            next_st.res.cycles = take ? `BDCT_LONG_TK : `BDCT_LONG_NT;
            if (i_op == `BDCT_OP_BRN) begin
              next_st.res.cycles = `BDCT_LBRA_CYC;
            end
            if (take) begin
              next_st.res.target = rel_target(i_pc, i_offset);
            end
          end else begin
            next_st.res.legal = 1'b0;
          end
        end
      end
      default: next_st.state = BDCT_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st <= '{state: BDCT_IDLE, pfx: 8'h00, res: '0};
      add_r <= '0;
    end else begin
      st <= next_st;
      add_r <= add8(i_add_a, i_add_b);
    end
  end

  assign o_valid    = st.res.valid;
  assign o_taken    = st.res.taken;
  assign o_target   = st.res.target;
  assign o_cycles   = st.res.cycles;
  assign o_nbytes   = st.res.nbytes;
  assign o_push_ret = st.res.push_ret;
  assign o_set_if   = st.res.set_if;
  assign o_legal    = st.res.legal;
  // Half-carry meaningful only after adds; unspecified elsewhere
  assign o_half     = add_r.half;
  assign o_carry    = add_r.carry;
  assign o_carry_b7 = add_r.h[`BDCT_SIGN_BIT];

  short_br_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_op_valid && st.state != BDCT_PFX && i_op[7:4] == 4'h2)
    |=> (o_valid && o_cycles == 5'h03 && o_nbytes == 3'h2))
    else $error("short branch timing wrong");
  long_pfx_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_op_valid && st.state != BDCT_PFX && i_op == 8'h10)
    |=> (st.state == BDCT_PFX && !o_valid))
    else $error("long prefix not held");
  long_cyc_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (st.state == BDCT_PFX && st.pfx == 8'h10 && i_op_valid &&
     i_op[7:4] == 4'h2 && i_op != 8'h21)
    |=> (o_nbytes == 3'h4 && o_cycles == (o_taken ? 5'h06 : 5'h05)))
    else $error("long branch timing wrong");
  stack_cyc_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_op_valid && st.state != BDCT_PFX && i_op == 8'h34 &&
     i_postbyte == 8'h01) |=> (o_cycles == 5'h06))
    else $error("push cycle count wrong");
  swi_mask_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (o_valid && o_set_if) |-> (o_cycles == 5'h13))
    else $error("mask set outside first soft interrupt");
  xfer_pair_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_op_valid && st.state != BDCT_PFX && i_op == 8'h1F &&
     i_postbyte == 8'h08) |=> !o_legal)
    else $error("mixed width transfer accepted");
  zero_br_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_op_valid && st.state != BDCT_PFX && i_op == 8'h27)
    |=> (o_taken == $past(i_cc[2])))
    else $error("zero branch decision wrong");
  signed_br_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_op_valid && st.state != BDCT_PFX && i_op == 8'h2D)
    |=> (o_taken == ($past(i_cc[3]) ^ $past(i_cc[1]))))
    else $error("signed less decision wrong");
  higher_br_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_op_valid && st.state != BDCT_PFX && i_op == 8'h22)
    |=> (o_taken == !($past(i_cc[0]) | $past(i_cc[2]))))
    else $error("unsigned higher decision wrong");
  half_add_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_add_a[3:0] == 4'hF && i_add_b[3:0] == 4'h1) |=> o_half)
    else $error("half carry lost");
  target_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_op_valid && st.state != BDCT_PFX && i_op == 8'h20)
    |=> (o_target == $past(i_pc) + {{8{$past(i_offset[7])}},
                                     $past(i_offset[7:0])}))
    else $error("branch target wrong");
endmodule
`default_nettype wire

/* File: tb/bdct_pmem.sv */
// Program memory model feeding opcode bytes to the decode block.
// Assumes one start pulse per instruction, held for one clock.
`timescale 1ns/1ps
`default_nettype none
module bdct_pmem (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_start,
  input  wire logic       i_two,
  input  wire logic       i_slow,
  input  wire logic [7:0] i_b0,
  input  wire logic [7:0] i_b1,
  output logic            o_op_valid,
  output logic [7:0]      o_op
);
  logic [1:0] ph;

  // Idle bytes are the inverse of the last one, never stale
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ph         <= 2'h0;
      o_op_valid <= 1'b0;
      o_op       <= 8'hFF;
    end else if (i_start) begin
      o_op_valid <= 1'b1;
      o_op       <= i_two ? i_b0 : i_b1;
      ph         <= !i_two ? 2'h0 : (i_slow ? 2'h2 : 2'h3);
    end else if (ph == 2'h3) begin
      o_op_valid <= 1'b1;
      o_op       <= i_b1;
      ph         <= 2'h0;
    end else begin
      o_op_valid <= 1'b0;
      o_op       <= ~o_op;
      ph         <= (ph == 2'h2) ? 2'h3 : 2'h0;
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the branch decode and cycle timing block.
// Assumes the package, the decode block and the memory model are compiled.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bdct_pkg::*;
  logic        mclk, rst, start, two, slow, op_valid, idx_mode;
  logic        o_valid, o_taken, o_push_ret, o_set_if, o_legal;
  logic        o_half, o_carry, o_carry_b7;
  logic [7:0]  b0, b1, op, cc, postbyte, add_a, add_b;
  logic [15:0] offset, pc, o_target;
  logic [4:0]  o_cycles;
  logic [3:0]  idx_cyc;
  logic [2:0]  o_nbytes;
  logic [1:0]  idx_len;
  int          errors, checks_done;

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  bdct_pmem u_mem (.i_mclk(mclk), .i_rst(rst), .i_start(start), .i_two(two),
    .i_slow(slow), .i_b0(b0), .i_b1(b1), .o_op_valid(op_valid), .o_op(op));

  bdct_decode DUT (.i_mclk(mclk), .i_rst(rst), .i_op_valid(op_valid),
    .i_op(op), .i_offset(offset), .i_pc(pc), .i_cc(cc),
    .i_postbyte(postbyte), .i_idx_cyc(idx_cyc), .i_idx_len(idx_len),
    .i_idx_mode(idx_mode), .i_add_a(add_a), .i_add_b(add_b),
    .o_valid(o_valid), .o_taken(o_taken), .o_target(o_target),
    .o_cycles(o_cycles), .o_nbytes(o_nbytes), .o_push_ret(o_push_ret),
    .o_set_if(o_set_if), .o_legal(o_legal), .o_half(o_half),
    .o_carry(o_carry), .o_carry_b7(o_carry_b7));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Issue one instruction and wait for its decode pulse
  task automatic run(input logic t, input logic s, input logic [7:0] a,
                     input logic [7:0] b);
    int n;
    two = t;
    slow = s;
    b0 = a;
    b1 = b;
    start = 1'b1;
    @(posedge mclk);
    #1 start = 1'b0;
    for (n = 0; n < 8 && o_valid !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    check(o_valid, 1'b1);
  endtask

  task automatic chk_br(input logic tk, input logic [15:0] tgt,
                        input logic [4:0] cyc, input logic [2:0] nb);
    check(o_taken, tk);
    if (tk) check(o_target, tgt);
    check(o_cycles, cyc);
    check(o_nbytes, nb);
  endtask

  function automatic logic cond(input logic [3:0] c, input logic [7:0] f);
    logic x;
    case (c[3:1])
      3'h0: x = 1'b0;
      3'h1: x = f[0] | f[2];
      3'h2: x = f[0];
      3'h3: x = f[2];
      3'h4: x = f[1];
      3'h5: x = f[3];
      3'h6: x = f[3] ^ f[1];
      default: x = f[2] | (f[3] ^ f[1]);
    endcase
    cond = c[0] ? x : !x;
  endfunction

  task automatic t_short();
    int o, f;
    for (o = 0; o < 16; o++) begin
      for (f = 0; f < 16; f++) begin
        cc = {4'h0, f[3:0]};
        offset = f[0] ? 16'hAB80 : 16'hFF7F;
        pc = 16'h4000 + 16'(f);
        run(1'b0, 1'b0, 8'hFF, {4'h2, o[3:0]});
        chk_br(cond(o[3:0], cc), pc + {{8{offset[7]}}, offset[7:0]},
               5'h03, 3'h2);
      end
    end
    $display("short branches done");
  endtask

  task automatic t_long();
    int o, f;
    logic tk;
    for (o = 1; o < 16; o++) begin
      for (f = 0; f < 16; f += 5) begin
        cc = {4'h0, f[3:0]};
        offset = 16'h8001;
        pc = 16'hFFF0;
        tk = cond(o[3:0], cc);
        run(1'b1, f[0], 8'h10, {4'h2, o[3:0]});
        chk_br(tk, pc + offset, tk ? 5'h06 : 5'h05, 3'h4);
      end
    end
    $display("long branches done");
  endtask

  task automatic t_simple();
    offset = 16'h0381;
    pc = 16'h1000;
    run(1'b0, 1'b0, 8'hFF, 8'h20);
    chk_br(1'b1, 16'h0F81, 5'h03, 3'h2);
    check(o_push_ret, 1'b0);
    run(1'b0, 1'b0, 8'hFF, 8'h21);
    chk_br(1'b0, 16'h0000, 5'h03, 3'h2);
    run(1'b0, 1'b0, 8'hFF, 8'h8D);
    chk_br(1'b1, 16'h0F81, 5'h07, 3'h2);
    check(o_push_ret, 1'b1);
    run(1'b0, 1'b0, 8'hFF, 8'h16);
    chk_br(1'b1, 16'h1381, 5'h05, 3'h3);
    run(1'b0, 1'b0, 8'hFF, 8'h17);
    chk_br(1'b1, 16'h1381, 5'h09, 3'h3);
    check(o_push_ret, 1'b1);
    $display("simple branches done");
  endtask

  task automatic t_stack();
    logic [7:0] m [5] = '{8'h00, 8'hFF, 8'h0F, 8'hF0, 8'h01};
    int o, k, n;
    for (o = 0; o < 4; o++) begin
      for (k = 0; k < 5; k++) begin
        postbyte = m[k];
        n = $countones(m[k][3:0]) + 2 * $countones(m[k][7:4]);
        run(1'b0, 1'b0, 8'hFF, 8'h34 + 8'(o));
        check(o_cycles, 16'(5 + n));
        check(o_nbytes, 3'h2);
      end
    end
    $display("stack done");
  endtask

  task automatic t_swi();
    run(1'b0, 1'b0, 8'hFF, 8'h3F);
    check(o_set_if, 1'b1);
    check(o_cycles, 5'h13);
    run(1'b1, 1'b0, 8'h10, 8'h3F);
    check(o_set_if, 1'b0);
    check(o_cycles, 5'h14);
    run(1'b1, 1'b1, 8'h11, 8'h3F);
    check(o_set_if, 1'b0);
    check(o_legal, 1'b1);
    run(1'b1, 1'b0, 8'h11, 8'h20);
    check(o_legal, 1'b0);
    $display("soft interrupts done");
  endtask

  task automatic t_xfr();
    logic [7:0] p [6] = '{8'h01, 8'h45, 8'h89, 8'hAB, 8'h08, 8'hB5};
    int o, k;
    for (o = 0; o < 2; o++) begin
      for (k = 0; k < 6; k++) begin
        postbyte = p[k];
        run(1'b0, 1'b0, 8'hFF, 8'h1E + 8'(o));
        check(o_legal, p[k][7] == p[k][3]);
        check(o_cycles, o ? 5'h06 : 5'h08);
      end
    end
    $display("exchange done");
  endtask

  task automatic t_idx();
    int k;
    idx_mode = 1'b1;
    for (k = 0; k < 4; k++) begin
      idx_cyc = 4'(k * 5);
      idx_len = 2'(k);
      run(1'b0, 1'b0, 8'hFF, 8'hA6);
      check(o_cycles, 16'(4 + k * 5));
      check(o_nbytes, 16'(2 + k));
    end
    idx_mode = 1'b0;
    $display("indexed done");
  endtask

  task automatic t_add();
    logic [7:0] a [4] = '{8'h08, 8'hF0, 8'h40, 8'hFF};
    logic [7:0] b [4] = '{8'h08, 8'h20, 8'h40, 8'h01};
    logic [8:0] s;
    int k;
    for (k = 0; k < 4; k++) begin
      add_a = a[k];
      add_b = b[k];
      s = {1'b0, a[k]} + {1'b0, b[k]};
      @(posedge mclk);
      #1;
      check(o_half, (a[k][3:0] + b[k][3:0]) > 5'h0F);
      check(o_carry, s[8]);
      check(o_carry_b7, s[7]);
    end
    $display("flag adder done");
  endtask

  initial begin
    rst = 1'b1;
    {start, two, slow, idx_mode} = 4'h0;
    {b0, b1, cc, postbyte, add_a, add_b} = '0;
    {offset, pc, idx_cyc, idx_len} = '0;
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    t_short();
    t_long();
    t_simple();
    t_stack();
    t_swi();
    t_xfr();
    t_idx();
    t_add();
    end_sim();
  end

  initial begin
    #100000;
    errors++;
    end_sim();
  end
endmodule
`default_nettype wire
